/* dv/spi_front_props.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_front_props #(
   parameter MEM_BYTES = 512
) (
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       spi_clk,
   input wire logic       spi_cs_n,
   input wire logic       miso_o,
   input wire logic       miso_oe,
   input wire logic       write_armed,
   input wire logic       write_is_mem,
   input wire logic       write_start_r,
   input wire logic       write_refused_r,
   input wire logic       write_enable_latch,
   input wire logic       write_in_progress,
   input wire logic [8:0] mem_top_r,
   input wire logic       selected_r,
   input wire logic       standby_r,
   input wire logic       hold_active_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ------
   // Select arming helper
   // ------
   logic cs_seen_r;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         cs_seen_r <= 1'b0;
      else if (spi_cs_n)
         cs_seen_r <= 1'b1;
   end
   // ------
   // Properties
   // ------
   property p_desel; spi_cs_n [*5] |-> !miso_oe && !selected_r; endproperty
   a_desel: assert property (p_desel)
      else $error("Driving or selected while chip select high");
   property p_hold_float; hold_active_r [*2] |-> !miso_oe; endproperty
   a_hold_float: assert property (p_hold_float)
      else $error("Output driven during hold");
   property p_active; selected_r [*2] |-> !standby_r; endproperty
   a_active: assert property (p_active)
      else $error("Standby while selected");
   property p_busy; write_in_progress [*2] |-> !standby_r; endproperty
   a_busy: assert property (p_busy)
      else $error("Standby during write cycle");
   // Selection without a prior high level means a missed arming edge
   property p_arm; selected_r |-> cs_seen_r; endproperty
   a_arm: assert property (p_arm)
      else $error("Selected without a select falling edge");
   property p_start; write_start_r |-> write_armed ##1 (write_in_progress && !write_enable_latch); endproperty
   a_start: assert property (p_start)
      else $error("Write start without cause or effect");
   property p_refuse; write_refused_r |-> write_is_mem && !write_start_r ##1 !write_in_progress; endproperty
   a_refuse: assert property (p_refuse)
      else $error("Refusal wrong");
   property p_shift; miso_oe && $past(miso_oe) && $changed(miso_o) |-> !$past(spi_clk, 2); endproperty
   a_shift: assert property (p_shift)
      else $error("Output changed outside clock low phase");
   property p_top; $past(reset_n, 3) |-> mem_top_r == 9'(MEM_BYTES - 1); endproperty
   a_top: assert property (p_top)
      else $error("Array top address wrong");
endmodule
bind spi_front spi_front_props #(.MEM_BYTES(MEM_BYTES)) u_spi_front_props (
   .clk_sys, .reset_n, .spi_clk, .spi_cs_n, .miso_o, .miso_oe, .write_armed, .write_is_mem,
   .write_start_r, .write_refused_r, .write_enable_latch, .write_in_progress, .mem_top_r,
   .selected_r, .standby_r, .hold_active_r
);
`default_nettype wire

/* dv/spi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   input  wire logic miso_o,
   input  wire logic miso_oe,
   output var logic  spi_clk,
   output var logic  spi_cs_n,
   output var logic  spi_mosi,
   output var logic  hold_n
);
   // ------
   // Mode 0 master, clock idles low
   // ------
   logic q;
   // Released line shows the inverse, not a stale copy
   assign q = miso_oe ? miso_o : ~miso_o;
   initial begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b0;
      spi_mosi = 1'b0;
      hold_n = 1'b1;
   end
   task sel(input logic lvl);
      #32 spi_cs_n = lvl;
      #32;
   endtask
   task xfer(input logic [7:0] mo, input int nb, input int hp, output logic [7:0] mi);
      mi = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
         spi_mosi = mo[i];
         if (i == hp) begin
            hold_n = 1'b0;
            #32 spi_clk = 1'b1;
            #32 spi_clk = 1'b0;
            spi_mosi = ~mo[i];
            #32 hold_n = 1'b1;
            spi_mosi = mo[i];
         end
         #32 spi_clk = 1'b1;
         mi[i] = q;
         #32 spi_clk = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk_sys, reset_n, wp_n, rx_ready, tx_valid, write_armed, write_is_mem, write_done;
   logic       wel_set, wel_clr, id_locked, spi_clk, spi_cs_n, spi_mosi, hold_n, miso_o, miso_oe;
   logic       rx_valid, rx_overrun_r, rx_first_r, tx_take_r, write_start_r, write_refused_r;
   logic       write_enable_latch, write_in_progress, status_write_disable, block_protect_hi;
   logic       block_protect_lo, id_page_ro_r, selected_r, standby_r, hold_active_r;
   logic [7:0] tx_data, rx_data, mi;
   logic [2:0] nv_status;
   logic [8:0] mem_top_r;
   logic [7:0] got[$];
   logic [15:0] rows [4] = '{16'hA55A, 16'h01FE, 16'h8000, 16'h7FFF};
   int         err_count, samples_checked, cyc, n_start, n_ref, n_take;
   spi_front u_spi_front (
      .clk_sys, .reset_n, .spi_clk, .spi_cs_n, .spi_mosi, .hold_n, .wp_n, .miso_o, .miso_oe,
      .rx_data, .rx_valid, .rx_ready, .rx_overrun_r, .rx_first_r, .tx_data, .tx_valid, .tx_take_r,
      .write_armed, .write_is_mem, .write_start_r, .write_refused_r, .write_done, .wel_set, .wel_clr,
      .write_enable_latch, .write_in_progress, .nv_status, .status_write_disable, .block_protect_hi,
      .block_protect_lo, .id_locked, .id_page_ro_r, .mem_top_r, .selected_r, .standby_r, .hold_active_r
   );
   spi_master_model u_spi_master_model (.miso_o, .miso_oe, .spi_clk, .spi_cs_n, .spi_mosi, .hold_n);
   // ------
   // Helpers
   // ------
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task chk_b(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task chk_f(input logic g, input logic e);
      chk_b({7'h00, g}, {7'h00, e});
   endtask
   task close_out;
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Level at commit differs from level during the frame
   task commit(input logic wp, input int nb, input int es, input int er);
      wp_n = ~wp;
      write_armed = 1'b1;
      write_is_mem = 1'b1;
      wel_set = 1'b1;
      tick(1);
      wel_set = 1'b0;
      u_spi_master_model.sel(1'b0);
      u_spi_master_model.xfer(8'h02, nb, -1, mi);
      wp_n = wp;
      u_spi_master_model.sel(1'b1);
      tick(2);
      write_armed = 1'b0;
      chk_b(8'(n_start), 8'(es));
      chk_b(8'(n_ref), 8'(er));
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
         got.push_back(rx_data);
      if (write_start_r === 1'b1)
         n_start++;
      if (write_refused_r === 1'b1)
         n_ref++;
      if (tx_take_r === 1'b1)
         n_take++;
      if (cyc == 20000) begin
         err_count++;
         close_out;
      end
   end
   // ------
   // Main sequence
   // ------
   initial begin
      {reset_n, write_armed, write_is_mem, write_done, wel_set, wel_clr} = 6'h00;
      {wp_n, rx_ready, tx_valid, id_locked} = 4'hF;
      tx_data = 8'h00;
      nv_status = 3'h5;
      tick(8);
      reset_n = 1'b1;
      tick(4);
      chk_f(standby_r, 1'b1);
      chk_f(write_in_progress, 1'b0);
      chk_f(write_enable_latch, 1'b0);
      chk_b({5'h00, status_write_disable, block_protect_hi, block_protect_lo}, 8'h05);
      chk_f(id_page_ro_r, 1'b1);
      // Chip select low since power-up: byte must be ignored
      u_spi_master_model.xfer(8'hC3, 8, -1, mi);
      tick(8);
      chk_b(8'(got.size()), 8'h00);
      u_spi_master_model.sel(1'b1);
      foreach (rows[i]) begin
         tick(1);
         tx_data = rows[i][7:0];
         u_spi_master_model.sel(1'b0);
         u_spi_master_model.xfer(rows[i][15:8], 8, -1, mi);
         chk_f(rx_first_r, 1'b1);
         u_spi_master_model.xfer(8'h00, 8, i * 2, mi);
         u_spi_master_model.sel(1'b1);
         chk_b(mi, rows[i][7:0]);
         chk_b(got.pop_front(), rows[i][15:8]);
         chk_b(got.pop_front(), 8'h00);
         chk_f(rx_first_r, 1'b0);
      end
      // No byte offered: output floats, partial byte dropped
      tick(1);
      tx_valid = 1'b0;
      n_take = 0;
      u_spi_master_model.sel(1'b0);
      u_spi_master_model.xfer(8'h3C, 8, -1, mi);
      u_spi_master_model.xfer(8'h00, 4, -1, mi);
      chk_f(miso_oe, 1'b0);
      u_spi_master_model.sel(1'b1);
      chk_b(8'(n_take), 8'h00);
      chk_f(rx_first_r, 1'b1);
      chk_b(got.pop_front(), 8'h3C);
      tx_valid = 1'b1;
      tick(1);
      rx_ready = 1'b0;
      u_spi_master_model.sel(1'b0);
      for (int k = 0; k < 9; k++)
         u_spi_master_model.xfer(8'(k), 8, -1, mi);
      u_spi_master_model.sel(1'b1);
      chk_b(8'(n_take), 8'h09);
      tick(4);
      chk_f(rx_overrun_r, 1'b1);
      rx_ready = 1'b1;
      tick(12);
      chk_b(8'(got.size()), 8'h08);
      foreach (got[k])
         chk_b(got[k], 8'(k));
      commit(1'b1, 8, 1, 0);
      chk_f(write_in_progress, 1'b1);
      chk_f(standby_r, 1'b0);
      write_done = 1'b1;
      tick(1);
      write_done = 1'b0;
      tick(3);
      chk_f(standby_r, 1'b1);
      commit(1'b0, 8, 1, 1);
      commit(1'b1, 4, 1, 1);
      chk_f(write_enable_latch, 1'b1);
      {wel_set, wel_clr} = 2'h3;
      tick(1);
      chk_f(write_enable_latch, 1'b1);
      wel_set = 1'b0;
      tick(1);
      wel_clr = 1'b0;
      chk_f(write_enable_latch, 1'b0);
      // Latch set again so the reset below has something to clear
      wel_set = 1'b1;
      nv_status = 3'h2;
      id_locked = 1'b0;
      tick(1);
      wel_set = 1'b0;
      reset_n = 1'b0;
      tick(3);
      reset_n = 1'b1;
      tick(4);
      chk_f(write_enable_latch, 1'b0);
      chk_f(selected_r, 1'b0);
      chk_f(standby_r, 1'b1);
      chk_b({5'h00, status_write_disable, block_protect_hi, block_protect_lo}, 8'h02);
      chk_f(id_page_ro_r, 1'b0);
      close_out;
   end
endmodule
`default_nettype wire

/* logic/spi_front.v */
// Notes on behaviour
// - Output bits change after falling clock edges
// - Input bits captured on rising clock edges
// - Chip select high: deselected, output floated
// - Deselected and no write: standby
// - Chip select low selects, active power
// - Ignore instructions until first select falling edge
// - Hold pauses exchange, keeps transfer progress; release enables output only mid-byte after a whole byte, offered or not
// - Hold floats output, ignores data and clock
// - Write protect low refuses memory writes
// - No reaction while power-on reset held
// - After reset: deselected, standby, needs new edge
// - Reset clears write-enable and in-progress bits
// - Reset keeps non-volatile status bits
// - Array byte wide, 128/256/512 bytes
// - Optional lockable sixteen-byte identification page
// - All bytes most significant bit first
// - Hold starts and ends only with clock low; deselect also ends it at any clock level
// - Write starts only after whole bytes
`timescale 1ns/1ps
`default_nettype none
`include "spi_front_consts.vh"

// ----------------------------------------
// Receive byte buffer
// ----------------------------------------
module byte_fifo #(
   parameter W = `BYTE_W,
   parameter D = `RX_FIFO_DEPTH,
   parameter A = 3
) (
   input  wire         clk_sys,
   input  wire         reset_n,
   input  wire [W-1:0] in_data,
   input  wire         in_valid,
   output wire         in_ready,
   output wire [W-1:0] out_data,
   output wire         out_valid,
   input  wire         out_ready
);
   reg [W-1:0] mem [0:D-1];
   reg [A-1:0] wr_ptr_r, rd_ptr_r;
   reg [A:0]   fill_r;
   wire        push, pop;

   assign in_ready  = (fill_r != D[A:0]);
   assign out_valid = (fill_r != {(A+1){1'b0}});
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_r <= {A{1'b0}};
         rd_ptr_r <= {A{1'b0}};
         fill_r   <= {(A+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == D[A-1:0] - 1'b1) ? {A{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == D[A-1:0] - 1'b1) ? {A{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push & ~pop) begin
            fill_r <= fill_r + 1'b1;
         end else if (pop & ~push) begin
            fill_r <= fill_r - 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------
// Serial pin front end
// ----------------------------------------
module spi_front #(
   parameter MEM_BYTES = `MEM_BYTES_DEF,
   parameter ID_PAGE   = `ID_PAGE_DEF
) (
   input  wire                  clk_sys,
   input  wire                  reset_n,
   input  wire                  spi_clk,
   input  wire                  spi_cs_n,
   input  wire                  spi_mosi,
   input  wire                  hold_n,
   input  wire                  wp_n,
   output reg                   miso_o,
   output reg                   miso_oe,
   output wire [`BYTE_W-1:0]    rx_data,
   output wire                  rx_valid,
   input  wire                  rx_ready,
   output reg                   rx_overrun_r,
   output reg                   rx_first_r,
   input  wire [`BYTE_W-1:0]    tx_data,
   input  wire                  tx_valid,
   output reg                   tx_take_r,
   input  wire                  write_armed,
   input  wire                  write_is_mem,
   output reg                   write_start_r,
   output reg                   write_refused_r,
   input  wire                  write_done,
   input  wire                  wel_set,
   input  wire                  wel_clr,
   output reg                   write_enable_latch,
   output reg                   write_in_progress,
   input  wire [`NV_W-1:0]      nv_status,
   output reg                   status_write_disable,
   output reg                   block_protect_hi,
   output reg                   block_protect_lo,
   input  wire                  id_locked,
   output reg                   id_page_ro_r,
   output reg [`MEM_TOP_W-1:0]  mem_top_r,
   output reg                   selected_r,
   output reg                   standby_r,
   output reg                   hold_active_r
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Chip select resets low so a pin already low at release gives no edge
   reg                   clk_m_r, clk_s_r, clk_d_r;
   reg                   cs_m_r, cs_s_r, cs_d_r;
   reg                   hold_m_r, hold_s_r, hold_d_r;
   reg                   mosi_m_r, mosi_s_r, wp_m_r, wp_s_r;
   reg                   armed_r, byte_seen_r, rx_push_r, first_pend_r;
   reg [`BIT_CNT_W-1:0]  bit_cnt_r;
   reg [`BYTE_W-1:0]     rx_shift_r, tx_shift_r, rx_byte_r;
   wire                  clk_rise, clk_fall, cs_fall, cs_rise;
   wire                  hold_fall, hold_rise, live, fifo_ready;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         clk_m_r  <= `SYNC_RST_LOW;
         clk_s_r  <= `SYNC_RST_LOW;
         clk_d_r  <= `SYNC_RST_LOW;
         cs_m_r   <= `SYNC_RST_LOW;
         cs_s_r   <= `SYNC_RST_LOW;
         cs_d_r   <= `SYNC_RST_LOW;
         hold_m_r <= `SYNC_RST_HIGH;
         hold_s_r <= `SYNC_RST_HIGH;
         hold_d_r <= `SYNC_RST_HIGH;
         mosi_m_r <= `SYNC_RST_LOW;
         mosi_s_r <= `SYNC_RST_LOW;
         wp_m_r   <= `SYNC_RST_LOW;
         wp_s_r   <= `SYNC_RST_LOW;
      end else begin
         clk_m_r  <= spi_clk;
         clk_s_r  <= clk_m_r;
         clk_d_r  <= clk_s_r;
         cs_m_r   <= spi_cs_n;
         cs_s_r   <= cs_m_r;
         cs_d_r   <= cs_s_r;
         hold_m_r <= hold_n;
         hold_s_r <= hold_m_r;
         hold_d_r <= hold_s_r;
         mosi_m_r <= spi_mosi;
         mosi_s_r <= mosi_m_r;
         wp_m_r   <= wp_n;
         wp_s_r   <= wp_m_r;
      end
   end

   assign clk_rise  = clk_s_r & ~clk_d_r;
   assign clk_fall  = ~clk_s_r & clk_d_r;
   assign cs_fall   = ~cs_s_r & cs_d_r;
   assign cs_rise   = cs_s_r & ~cs_d_r;
   assign hold_fall = ~hold_s_r & hold_d_r;
   assign hold_rise = hold_s_r & ~hold_d_r;
   // Edges count only when selected, armed and not paused
   assign live      = selected_r & ~hold_active_r;

   // ----------------------------------------
   // Selection, hold and power state
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         armed_r       <= 1'b0;
         selected_r    <= 1'b0;
         standby_r     <= `STANDBY_RST;
         hold_active_r <= 1'b0;
      end else begin
         if (cs_fall) begin
            armed_r <= 1'b1;
         end
         selected_r <= ~cs_s_r & (armed_r | cs_fall);
         standby_r  <= ~(~cs_s_r & (armed_r | cs_fall)) & ~write_in_progress;
         if (cs_s_r) begin
            // Deselect during a pause also aborts the frame
            hold_active_r <= 1'b0;
         end else if (selected_r & hold_fall & ~clk_s_r) begin
            hold_active_r <= 1'b1;
         end else if (hold_rise & ~clk_s_r) begin
            hold_active_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Bit shifting
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt_r    <= `BIT_CNT_ZERO;
         byte_seen_r  <= 1'b0;
         rx_shift_r   <= {`BYTE_W{1'b0}};
         tx_shift_r   <= {`BYTE_W{1'b0}};
         miso_o       <= 1'b0;
         miso_oe      <= 1'b0;
         rx_push_r    <= 1'b0;
         rx_byte_r    <= {`BYTE_W{1'b0}};
         rx_overrun_r <= 1'b0;
         rx_first_r   <= 1'b0;
         first_pend_r <= 1'b0;
         tx_take_r    <= 1'b0;
      end else begin
         rx_push_r <= 1'b0;
         tx_take_r <= 1'b0;
         if (!selected_r) begin
            bit_cnt_r    <= `BIT_CNT_ZERO;
            byte_seen_r  <= 1'b0;
            miso_oe      <= 1'b0;
            first_pend_r <= 1'b1;
         end else begin
            if (live & clk_rise) begin
               rx_shift_r <= {rx_shift_r[`BYTE_MSB-1:0], mosi_s_r};
               bit_cnt_r  <= bit_cnt_r + 1'b1;
               if (bit_cnt_r == {`BIT_CNT_W{1'b1}}) begin
                  byte_seen_r  <= 1'b1;
                  rx_push_r    <= 1'b1;
                  rx_byte_r    <= {rx_shift_r[`BYTE_MSB-1:0], mosi_s_r};
                  rx_first_r   <= first_pend_r;
                  first_pend_r <= 1'b0;
               end
            end
            if (live & clk_fall & byte_seen_r) begin
               // A fresh byte loads at each byte edge; no byte means float
               if (bit_cnt_r == `BIT_CNT_ZERO) begin
                  tx_shift_r <= {tx_data[`BYTE_MSB-1:0], 1'b0};
                  miso_o     <= tx_data[`BYTE_MSB];
                  miso_oe    <= tx_valid;
                  tx_take_r  <= tx_valid;
               end else begin
                  tx_shift_r <= {tx_shift_r[`BYTE_MSB-1:0], 1'b0};
                  miso_o     <= tx_shift_r[`BYTE_MSB];
               end
            end
            if (hold_active_r & hold_rise & ~clk_s_r) begin
               miso_oe <= byte_seen_r & (bit_cnt_r != `BIT_CNT_ZERO);
            end else if (hold_active_r) begin
               miso_oe <= 1'b0;
            end
         end
         // Byte lost when the reader stalls: the link cannot be held off
         if (rx_push_r & ~fifo_ready) begin
            rx_overrun_r <= 1'b1;
         end else if (cs_fall) begin
            rx_overrun_r <= 1'b0;
         end
      end
   end

   byte_fifo #(
      .W (`BYTE_W),
      .D (`RX_FIFO_DEPTH),
      .A (3)
   ) u_rx_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_data   (rx_byte_r),
      .in_valid  (rx_push_r),
      .in_ready  (fifo_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

   // ----------------------------------------
   // Write cycle start and status bits
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         write_start_r      <= 1'b0;
         write_refused_r    <= 1'b0;
         write_enable_latch <= `WEL_RST;
         write_in_progress  <= `WIP_RST;
      end else begin
         write_start_r   <= 1'b0;
         write_refused_r <= 1'b0;
         if (cs_rise & selected_r & write_armed & ~write_in_progress &
             byte_seen_r & (bit_cnt_r == `BIT_CNT_ZERO)) begin
            if (write_is_mem & ~wp_s_r) begin
               write_refused_r <= 1'b1;
            end else begin
               write_start_r <= 1'b1;
            end
         end
         // Start wins over a finish in the same cycle
         if (write_start_r) begin
            write_in_progress <= 1'b1;
         end else if (write_done) begin
            write_in_progress <= 1'b0;
         end
         if (wel_set) begin
            write_enable_latch <= 1'b1;
         end else if (wel_clr | write_start_r) begin
            write_enable_latch <= 1'b0;
         end
      end
   end

   // Stored bits follow the store, untouched by reset
   always @(posedge clk_sys) begin
      status_write_disable <= nv_status[`NV_SWD_BIT];
      block_protect_hi     <= nv_status[`NV_BPH_BIT];
      block_protect_lo     <= nv_status[`NV_BPL_BIT];
   end

   // ----------------------------------------
   // Array geometry
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_top_r    <= {`MEM_TOP_W{1'b0}};
         id_page_ro_r <= 1'b0;
      end else begin
         mem_top_r    <= MEM_BYTES[`MEM_TOP_W-1:0] - 1'b1;
         id_page_ro_r <= (ID_PAGE != 0) & id_locked;
      end
   end
endmodule
`default_nettype wire

/* logic/spi_front_consts.vh */
`ifndef SPI_FRONT_CONSTS_VH
`define SPI_FRONT_CONSTS_VH

// ----------------------------------------
// Frame and byte layout
// ----------------------------------------
`define BYTE_W          8
`define BIT_CNT_W       3
`define BIT_CNT_ZERO    3'h0
`define BYTE_MSB        7

// ----------------------------------------
// Buffer and array sizes
// ----------------------------------------
`define RX_FIFO_DEPTH   8
`define MEM_BYTES_DEF   512
`define MEM_TOP_W       9
`define ID_PAGE_BYTES   16
`define ID_PAGE_DEF     1

// ----------------------------------------
// Non-volatile status field positions
// ----------------------------------------
`define NV_W            3
`define NV_SWD_BIT      2
`define NV_BPH_BIT      1
`define NV_BPL_BIT      0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SYNC_RST_LOW    1'b0
`define SYNC_RST_HIGH   1'b1
`define WEL_RST         1'b0
`define WIP_RST         1'b0
`define STANDBY_RST     1'b1

`endif
